// [logic/mode_strap_led.sv]
`timescale 1ns/1ps
`include "mode_strap_regs.svh"
// Function
// - pin pair after reset picks mode code
// - mode lands in register 19 bits 15..11
// - code 00000 presets 10 Mb/s half
// - code 00001 presets 10 Mb/s full
// - code 00010 presets 100 Mb/s half
// - code 00011 presets 100 Mb/s full
// - code 00100 presets autoneg, advert 0100
// - code 00111 presets auto master/slave
// - code 01001 presets forced slave role
// - code 01010 presets forced master role
// - registers are 16-bit words to software
// - duplex lamp follows resolution, not link
// - after the pin probe, speed lamps only with link up
// - two-bit scheme select, default three
// - scheme one colours, 10 Mb/s alternates
// - scheme two swaps colours, shows collision
// - schemes one/two duplex pair colour table
// - schemes one/two: activity blinks the duplex colour
// - scheme three steady speed lamps, blink
// - pin decoded to one of four levels
// - soft reset keeps register configuration
module mode_strap_led
  import mode_strap_pkg::*;
#(
  parameter int BLINK_HALF_CYC =
    `BLINK_PERIOD_MS * 1000000 / `CLK_PERIOD_NS / 2
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic mode_select_pin_high_i,
  input wire logic mode_select_pin_low_i,
  input wire link_stat_t link_status_i,
  output logic gigabit_indicator_o,
  output logic fast_speed_indicator_o,
  output logic low_speed_indicator_o,
  output logic duplex_indicator_o,
  output logic soft_reset_o
);

  strap_state_t state_q, state_d;
  logic [1:0] samp_a_q, samp_b_q;
  logic [15:0] reg0_q, reg4_q, reg9_q, reg19_q;
  logic [22:0] blink_cnt_q;
  logic blink_q, alt_q;
  led_t led_q, led_d;
  logic aw_rdy_q, w_rdy_q, ar_rdy_q, bvalid_q, rvalid_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic soft_rst_q;

  // power-up probe sequencer
  always_comb begin
    case (state_q)
      ST_DRIVE_A: state_d = ST_SAMPLE_A;
      ST_SAMPLE_A: state_d = ST_DRIVE_B;
      ST_DRIVE_B: state_d = ST_SAMPLE_B;
      ST_SAMPLE_B: state_d = ST_APPLY;
      ST_APPLY: state_d = ST_RUN;
      ST_RUN: state_d = ST_RUN;
      default: state_d = ST_RUN;
    endcase
  end

  // every rst_i reset restarts the probe, so the pins are read afresh each time; soft reset does not
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_DRIVE_A;
    end else begin
      state_q <= state_d;
    end
  end

  // pin probe: phase a drives the fast lamp high, phase b the gigabit
  // lamp; a pin tied to a lamp follows it, rails read fixed. each pin
  // is sampled a cycle after the fast drive and two after the gigabit drive so the board can settle.
  wire [1:0] pins_w = {mode_select_pin_high_i, mode_select_pin_low_i};
  wire [1:0] cpv_w [2];
  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_pin
      always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
          samp_a_q[gp] <= 1'b0;
          samp_b_q[gp] <= 1'b0;
        end else begin
          if (state_q == ST_SAMPLE_A) samp_a_q[gp] <= pins_w[gp];
          if (state_q == ST_SAMPLE_B) samp_b_q[gp] <= pins_w[gp];
        end
      end
      assign cpv_w[gp] = {samp_b_q[gp], samp_a_q[gp]};
    end
  endgenerate

  // mode code from the two pin levels; levels 0/1 on the high pin
  // are not listed, so they fall back to the all-capable auto mode
  logic [4:0] strap_mode;
  always_comb begin
    strap_mode = `MODE_ALL_AUTO;
    if (cpv_w[1] == `CPV_GIG) begin
      strap_mode = {3'h0, cpv_w[0]};
    end else if (cpv_w[1] == `CPV_VDD) begin
      case (cpv_w[0])
        `CPV_FAST: strap_mode = `MODE_100AN;
        `CPV_GIG: strap_mode = `MODE_ALL_SLAVE;
        `CPV_VDD: strap_mode = `MODE_ALL_MASTER;
        default: strap_mode = `MODE_ALL_AUTO;
      endcase
    end
  end

  // preset pattern per mode: reg0 {13,12,8,6}, advert, master/slave
  logic [3:0] p_r0;
  logic p_keep8, p_adv_en, p_ms_full;
  logic [3:0] p_adv;
  logic [4:0] p_ms;
  logic p_ok;
  always_comb begin
    p_r0 = 4'h0;
    p_keep8 = 1'b0;
    p_adv_en = 1'b0;
    p_adv = 4'h0;
    p_ms_full = 1'b0;
    p_ms = 5'h00;
    p_ok = 1'b1;
    case (strap_mode)
      `MODE_10H: p_r0 = 4'h0;
      `MODE_10F: p_r0 = 4'h2;
      `MODE_100H: p_r0 = 4'h8;
      `MODE_100F: p_r0 = 4'hA;
      `MODE_100AN: begin
        p_r0 = 4'hC;
        p_adv_en = 1'b1;
        p_adv = 4'h4;
      end
      `MODE_ALL_AUTO, `MODE_ALL_SLAVE, `MODE_ALL_MASTER: begin
        p_r0 = 4'h5; // duplex bit kept as is
        p_keep8 = 1'b1;
        p_adv_en = 1'b1;
        p_adv = 4'hF;
        p_ms_full = 1'b1;
        p_ms = 5'h03;
        if (strap_mode == `MODE_ALL_SLAVE) p_ms = 5'h13;
        if (strap_mode == `MODE_ALL_MASTER) p_ms = 5'h1F;
      end
      default: p_ok = 1'b0;
    endcase
  end

  // axi decode, all registers are 16-bit words in the low lanes
  wire do_write = !aw_rdy_q && !w_rdy_q && !bvalid_q;
  wire wr_r0 = do_write && awaddr_q == `OFF_BASIC_CTRL;
  wire wr_r4 = do_write && awaddr_q == `OFF_ADVERT;
  wire wr_r9 = do_write && awaddr_q == `OFF_MS_CTRL;
  wire wr_r19 = do_write && awaddr_q == `OFF_MODE_CTRL;
  wire wr_hit = wr_r0 || wr_r4 || wr_r9 || wr_r19 ||
    awaddr_q == `OFF_STATUS;
  wire [15:0] wmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [15:0] wdat16 = wdata_q[15:0];
  wire [15:0] status_w = {7'h00, state_q == ST_RUN, cpv_w[1], cpv_w[0],
    led_q.gig, led_q.fast, led_q.low, led_q.dup};
  wire ar_hs = s_axi_arvalid_i && ar_rdy_q;
  wire [7:0] ra = s_axi_araddr_i;
  wire rd_hit = ra == `OFF_BASIC_CTRL || ra == `OFF_ADVERT ||
    ra == `OFF_MS_CTRL || ra == `OFF_MODE_CTRL || ra == `OFF_STATUS;
  wire [15:0] rd16 =
    ra == `OFF_BASIC_CTRL ? reg0_q :
    ra == `OFF_ADVERT ? reg4_q :
    ra == `OFF_MS_CTRL ? reg9_q :
    ra == `OFF_MODE_CTRL ? reg19_q :
    ra == `OFF_STATUS ? status_w : 16'h0000;
  wire soft_rst_req = wr_r0 && wstrb_q[1] && wdat16[`B0_SOFT_RST];

  // write and read channels; address and data land in either order
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_rdy_q <= 1'b1;
      w_rdy_q <= 1'b1;
      ar_rdy_q <= 1'b1;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bresp_q <= `RESP_OKAY;
      rresp_q <= `RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid_i && aw_rdy_q) begin
        aw_rdy_q <= 1'b0;
        awaddr_q <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && w_rdy_q) begin
        w_rdy_q <= 1'b0;
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
      end
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready_i) begin
        bvalid_q <= 1'b0;
        aw_rdy_q <= 1'b1;
        w_rdy_q <= 1'b1;
      end
      if (ar_hs) begin
        ar_rdy_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= {16'h0000, rd16};
        rresp_q <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (rvalid_q && s_axi_rready_i) begin
        rvalid_q <= 1'b0;
        ar_rdy_q <= 1'b1;
      end
    end
  end

  // register file; the strap preset wins over a write in ST_APPLY.
  // soft reset is only a pulse: nothing here reloads from the pins
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      reg0_q <= 16'h0000;
      reg4_q <= 16'h0000;
      reg9_q <= 16'h0000;
      reg19_q <= {14'h0000, `SCHEME_RST};
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= soft_rst_req;
      if (state_q == ST_APPLY) begin
        reg19_q[`MODE_HI:`MODE_LO] <= strap_mode;
        if (p_ok) begin
          reg0_q[`B0_SPEED_LSB] <= p_r0[3];
          reg0_q[`B0_AN_EN] <= p_r0[2];
          if (!p_keep8) reg0_q[`B0_FULL_DUP] <= p_r0[1];
          reg0_q[`B0_SPEED_MSB] <= p_r0[0];
          if (p_adv_en) reg4_q[`ADV_HI:`ADV_LO] <= p_adv;
          if (p_ms_full) reg9_q[`MS_HI:`MS_LO] <= p_ms;
          else reg9_q[`MS_LO+1:`MS_LO] <= 2'h0;
        end
      end else begin
        // soft reset bit self clears, so it never stores
        if (wr_r0) reg0_q <= ((reg0_q & ~wmask) | (wdat16 & wmask)) &
          ~(16'h0001 << `B0_SOFT_RST);
        if (wr_r4) reg4_q <= (reg4_q & ~wmask) | (wdat16 & wmask);
        if (wr_r9) reg9_q <= (reg9_q & ~wmask) | (wdat16 & wmask);
        if (wr_r19) reg19_q <= (reg19_q & ~wmask) | (wdat16 & wmask);
      end
    end
  end

  // blink divider and colour-mix toggle; alt runs every cycle so the
  // mixed colour looks steady, blink is slow enough to see
  wire blink_end = blink_cnt_q == 23'(BLINK_HALF_CYC - 1);
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      blink_cnt_q <= 23'h000000;
      blink_q <= 1'b0;
      alt_q <= 1'b0;
    end else begin
      alt_q <= !alt_q;
      blink_cnt_q <= blink_end ? 23'h000000 : blink_cnt_q + 23'h000001;
      if (blink_end) blink_q <= !blink_q;
    end
  end

  // indicator selection
  wire [1:0] scheme = reg19_q[`SCHEME_HI:`SCHEME_LO];
  wire lk = link_status_i.link_up;
  wire act = link_status_i.activity;
  wire fd = link_status_i.full_duplex;
  wire res = link_status_i.duplex_resolved;
  wire sp10 = lk && link_status_i.speed == `SPD_10;
  wire sp100 = lk && link_status_i.speed == `SPD_100;
  wire sp1g = lk && link_status_i.speed == `SPD_1000;
  wire blk = act ? blink_q : 1'b1;
  wire col2 = scheme == `SCHEME_TWO && link_status_i.collision;
  always_comb begin
    led_d = '0;
    if (scheme == `SCHEME_ONE || scheme == `SCHEME_TWO) begin
      // colour 1 and 2 swap between the two schemes
      if (scheme == `SCHEME_ONE) begin
        led_d.fast = sp100 || (sp10 && alt_q);
        led_d.gig = sp1g || (sp10 && !alt_q);
      end else begin
        led_d.gig = sp1g || (sp10 && alt_q);
        led_d.fast = sp100 || (sp10 && !alt_q);
      end
      if (col2 && lk) begin
        led_d.low = alt_q;
        led_d.dup = !alt_q;
      end else if (res) begin
        led_d.dup = fd && (act ? !blink_q : 1'b1);
        led_d.low = lk && act && blink_q;
      end
    end else begin
      led_d.gig = sp1g && blk;
      led_d.fast = sp100 && blk;
      led_d.low = sp10 && blk;
      led_d.dup = res && fd;
    end
  end

  // lamps double as probe drives until the mode is taken
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      led_q <= '0;
    end else if (state_d == ST_DRIVE_B || state_d == ST_SAMPLE_B) begin
      led_q <= '{gig: 1'b1, fast: 1'b0, low: 1'b0, dup: 1'b0};
    end else if (state_d != ST_RUN) begin
      led_q <= '{gig: 1'b0, fast: 1'b1, low: 1'b0, dup: 1'b0};
    end else begin
      led_q <= led_d;
    end
  end

  // ports are plain copies of flops, no logic after the register
  assign gigabit_indicator_o = led_q.gig;
  assign fast_speed_indicator_o = led_q.fast;
  assign low_speed_indicator_o = led_q.low;
  assign duplex_indicator_o = led_q.dup;
  assign soft_reset_o = soft_rst_q;
  assign s_axi_awready_o = aw_rdy_q;
  assign s_axi_wready_o = w_rdy_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_arready_o = ar_rdy_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;

  // checks on the strap preset, soft reset and lamps
  AST_MODE_FROM_PINS: assert property (@(posedge mclk_i) disable iff (rst_i)
    state_q == ST_APPLY && cpv_w[1] == `CPV_VDD && cpv_w[0] == `CPV_GIG
    |=> reg19_q[`MODE_HI:`MODE_LO] == 5'h09)
    else $error("slave strap did not give mode 01001");
  AST_MODE_FIELD: assert property (@(posedge mclk_i) disable iff (rst_i)
    state_q == ST_APPLY |=> reg19_q[`MODE_HI:`MODE_LO] == $past(strap_mode))
    else $error("mode field not loaded from pins");
  AST_PRESET_10H: assert property (@(posedge mclk_i) disable iff (rst_i)
    state_q == ST_APPLY && strap_mode == `MODE_10H
    |=> {reg0_q[`B0_SPEED_LSB], reg0_q[`B0_AN_EN], reg0_q[`B0_FULL_DUP],
    reg0_q[`B0_SPEED_MSB], reg9_q[`MS_LO+1:`MS_LO]} == 6'h00)
    else $error("10 half preset wrong");
  AST_PRESET_AN: assert property (@(posedge mclk_i) disable iff (rst_i)
    state_q == ST_APPLY && strap_mode == `MODE_100AN
    |=> reg0_q[`B0_SPEED_LSB] && reg0_q[`B0_AN_EN] && reg4_q[`ADV_HI:`ADV_LO] == 4'h4)
    else $error("100 autoneg preset wrong");
  AST_PRESET_MASTER: assert property (@(posedge mclk_i) disable iff (rst_i)
    state_q == ST_APPLY && strap_mode == `MODE_ALL_MASTER
    |=> reg9_q[`MS_HI:`MS_LO] == 5'h1F && reg4_q[`ADV_HI:`ADV_LO] == 4'hF &&
    $stable(reg0_q[`B0_FULL_DUP]))
    else $error("master preset wrong");
  AST_SOFT_KEEPS: assert property (@(posedge mclk_i) disable iff (rst_i)
    soft_rst_q |-> $stable(reg4_q) && $stable(reg9_q) && $stable(reg19_q))
    else $error("soft reset altered configuration");
  AST_NO_LINK_DARK: assert property (@(posedge mclk_i) disable iff (rst_i)
    state_q == ST_RUN && !lk ##1 state_q == ST_RUN
    |-> !gigabit_indicator_o && !fast_speed_indicator_o)
    else $error("speed lamp lit without link");
  AST_DUPLEX_EARLY: assert property (@(posedge mclk_i) disable iff (rst_i)
    state_q == ST_RUN && scheme == `SCHEME_RST && res && fd && !lk
    |=> duplex_indicator_o)
    else $error("duplex lamp waited for link");
  AST_TEN_MIX: assert property (@(posedge mclk_i) disable iff (rst_i)
    state_q == ST_RUN && scheme == `SCHEME_ONE && sp10 ##1 $stable(sp10)
    |-> gigabit_indicator_o != fast_speed_indicator_o)
    else $error("10 Mb/s colour mix broken");

endmodule

// [logic/mode_strap_regs.svh]
`ifndef MODE_STRAP_REGS_SVH
`define MODE_STRAP_REGS_SVH
// register byte offsets
`define OFF_BASIC_CTRL 8'h00
`define OFF_ADVERT 8'h04
`define OFF_MS_CTRL 8'h08
`define OFF_MODE_CTRL 8'h0C
`define OFF_STATUS 8'h10
// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// basic control bits
`define B0_SOFT_RST 15
`define B0_SPEED_LSB 13
`define B0_AN_EN 12
`define B0_FULL_DUP 8
`define B0_SPEED_MSB 6
// mode control fields
`define MODE_HI 15
`define MODE_LO 11
`define SCHEME_HI 1
`define SCHEME_LO 0
`define SCHEME_RST 2'h3
`define SCHEME_ONE 2'h1
`define SCHEME_TWO 2'h2
// advertisement bits 8..5, master/slave bits 12..8
`define ADV_HI 8
`define ADV_LO 5
`define MS_HI 12
`define MS_LO 8
// operating mode codes
`define MODE_10H 5'h00
`define MODE_10F 5'h01
`define MODE_100H 5'h02
`define MODE_100F 5'h03
`define MODE_100AN 5'h04
`define MODE_ALL_AUTO 5'h07
`define MODE_ALL_SLAVE 5'h09
`define MODE_ALL_MASTER 5'h0A
// pin connection values
`define CPV_GND 2'h0
`define CPV_FAST 2'h1
`define CPV_GIG 2'h2
`define CPV_VDD 2'h3
// link speeds
`define SPD_10 2'h0
`define SPD_100 2'h1
`define SPD_1000 2'h2
// blink timing
`define CLK_PERIOD_NS 5
`define BLINK_PERIOD_MS 40
`endif

// [logic/mode_strap_pkg.sv]
package mode_strap_pkg;
  // power-up sequence: probe the two pins, then preset, then run
  typedef enum logic [2:0] {
    ST_DRIVE_A,
    ST_SAMPLE_A,
    ST_DRIVE_B,
    ST_SAMPLE_B,
    ST_APPLY,
    ST_RUN
  } strap_state_t;
  // link state from the rest of the transceiver
  typedef struct packed {
    logic link_up;
    logic [1:0] speed;
    logic duplex_resolved;
    logic full_duplex;
    logic activity;
    logic collision;
  } link_stat_t;
  // the four indicator drives
  typedef struct packed {
    logic gig;
    logic fast;
    logic low;
    logic dup;
  } led_t;
endpackage

// [tb/strap_wiring.sv]
`timescale 1ns/1ps
// board wiring of the two mode pins: ground, a lamp output or supply
module strap_wiring (
  input wire logic [1:0] high_cpv_i,
  input wire logic [1:0] low_cpv_i,
  input wire logic fast_i,
  input wire logic gig_i,
  output logic high_o,
  output logic low_o
);
  // a lamp-strapped pin simply follows the lamp it is tied to
  function automatic logic lvl(input logic [1:0] c, input logic f, input logic g);
    return (c == 2'h0) ? 1'b0 : (c == 2'h1) ? f : (c == 2'h2) ? g : 1'b1;
  endfunction
  assign high_o = lvl(high_cpv_i, fast_i, gig_i);
  assign low_o = lvl(low_cpv_i, fast_i, gig_i);
endmodule

// [tb/mode_strap_led_tb.sv]
`timescale 1ns/1ps
module mode_strap_led_tb;
  import mode_strap_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid, soft_rst, hi_pin, lo_pin;
  logic gig, fast, low, dup;
  logic [1:0] bresp, rresp;
  logic [1:0] hc = 2'h0, lc = 2'h0;
  logic [3:0] wstrb = 4'hF;
  link_stat_t ls = '0;
  int errors = 0, checks = 0, pulses = 0;

  always #2.5 mclk_i = ~mclk_i;

  // short blink half period keeps blink scenarios to a few cycles
  mode_strap_led #(.BLINK_HALF_CYC(4)) mode_strap_led_i (
    .mclk_i(mclk_i), .rst_i(rst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .mode_select_pin_high_i(hi_pin), .mode_select_pin_low_i(lo_pin),
    .link_status_i(ls), .gigabit_indicator_o(gig), .fast_speed_indicator_o(fast),
    .low_speed_indicator_o(low), .duplex_indicator_o(dup), .soft_reset_o(soft_rst));

  strap_wiring strap_wiring_i (.high_cpv_i(hc), .low_cpv_i(lc), .fast_i(fast),
    .gig_i(gig), .high_o(hi_pin), .low_o(lo_pin));

  // soft reset must pulse, so count every cycle it is high
  always @(posedge mclk_i) begin
    if (soft_rst === 1'b1) pulses <= pulses + 1;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // address and data offered together, bready held until bvalid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge mclk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (n < 100) begin
      @(posedge mclk_i);
      n++;
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        bready <= 1'b0;
        check("bresp", 32'(bresp), 32'(er));
        n = 1000;
      end
    end
    if (n < 1000) errors++;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge mclk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (n < 100) begin
      @(posedge mclk_i);
      n++;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        rready <= 1'b0;
        d = rdata;
        check("rresp", 32'(rresp), 32'(er));
        check("rdata_hi", 32'(rdata[31:16]), 32'h0);
        n = 1000;
      end
    end
    if (n < 1000) errors++;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] d;
    rd(a, d, 2'h0);
    check(nm, d, e);
  endtask

  // registers are probed only after the five-edge strap sequence
  task automatic do_reset(input int n);
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (n) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge mclk_i);
  endtask

  task automatic lamp(input link_stat_t v, input logic [3:0] e, input string nm);
    @(posedge mclk_i);
    ls <= v;
    repeat (2) @(posedge mclk_i);
    #1 check(nm, 32'({gig, fast, low, dup}), 32'(e));
  endtask

  // counts fast, low, gig^fast and low^dup over sixteen cycles
  task automatic blink16(input link_stat_t v, output int nf, nl, ng, nx);
    nf = 0;
    nl = 0;
    ng = 0;
    nx = 0;
    @(posedge mclk_i);
    ls <= v;
    repeat (2) @(posedge mclk_i);
    repeat (16) begin
      #1;
      nf += int'(fast === 1'b1);
      nl += int'(low === 1'b1);
      ng += int'((gig ^ fast) === 1'b1);
      nx += int'((low ^ dup) === 1'b1);
      @(posedge mclk_i);
    end
  endtask

  // model of the pin-pair to mode-code table
  function automatic logic [4:0] code_of(input logic [1:0] h, input logic [1:0] l);
    if (h == 2'h2) return {3'h0, l};
    if (h == 2'h3) return (l == 2'h0) ? 5'h07 : (l == 2'h1) ? 5'h04 : (l == 2'h2) ? 5'h09 : 5'h0A;
    return 5'h07;
  endfunction

  // preset images; don't-care bits stay at their cleared reset value
  function automatic void preset(input logic [4:0] c, output logic [15:0] r0, r4, r9);
    r0 = 16'h0;
    r4 = 16'h0;
    r9 = 16'h0;
    case (c)
      5'h01: r0 = 16'h0100;
      5'h02: r0 = 16'h2000;
      5'h03: r0 = 16'h2100;
      5'h04: r0 = 16'h3000;
      5'h09: r9 = 16'h1300;
      5'h0A: r9 = 16'h1F00;
      default: r9 = (c == 5'h07) ? 16'h0300 : 16'h0;
    endcase
    if (c == 5'h04) r4 = 16'h0080;
    if (c >= 5'h07) begin
      r0 = 16'h1040;
      r4 = 16'h01E0;
    end
  endfunction

  // whole run is about six hundred cycles, so this only fires on a hang
  initial begin
    #100000;
    errors++;
    test_done();
  end

  initial begin
    logic [15:0] r0, r4, r9;
    logic [31:0] d;
    link_stat_t v;
    int p, nf, nl, ng, nx;
    void'($urandom(32'h8623412f));
    for (int i = 0; i < 16; i++) begin
      hc <= 2'(i >> 2);
      lc <= 2'(i);
      do_reset(i == 0 ? 11 : 3);
      preset(code_of(hc, lc), r0, r4, r9);
      rc(8'h0C, 32'({code_of(hc, lc), 9'h0, 2'h3}), "mode");
      rc(8'h00, 32'(r0), "ctrl");
      rc(8'h04, 32'(r4), "advert");
      rc(8'h08, 32'(r9), "ms_ctrl");
      rd(8'h10, d, 2'h0);
      check("pins", 32'(d[8:4]), 32'({1'b1, hc, lc}));
    end
    p = pulses;
    wr(8'h00, 32'(r0) | 32'h8000, 2'h0);
    repeat (4) @(posedge mclk_i);
    check("soft_pulse", 32'(pulses - p), 32'h1);
    rc(8'h00, 32'(r0), "ctrl_kept");
    wr(8'h0C, 32'h3, 2'h0);
    rc(8'h00, 32'(r0), "ctrl_mode_wr");
    rc(8'h0C, 32'h3, "mode_wr");
    wr(8'h20, 32'h1234, 2'h2);
    rd(8'h20, d, 2'h2);
    check("unmapped", d, 32'h0);
    wr(8'h10, 32'h0, 2'h0);
    rd(8'h10, d, 2'h0);
    check("status_ro", 32'(d[8:4]), 32'h1F);
    wstrb <= 4'h1;
    wr(8'h04, 32'hFFFF, 2'h0);
    wstrb <= 4'hF;
    rc(8'h04, 32'h01FF, "advert_lane");
    repeat (8) begin
      v = link_stat_t'(7'($urandom));
      v.link_up = 1'b0;
      v.duplex_resolved = 1'b1;
      v.activity = 1'b0;
      lamp(v, {3'h0, v.full_duplex}, "no_link");
    end
    lamp(link_stat_t'(7'b1011100), 4'b0101, "s3_100");
    lamp(link_stat_t'(7'b1101000), 4'b1000, "s3_gig");
    lamp(link_stat_t'(7'b1001100), 4'b0011, "s3_10");
    blink16(link_stat_t'(7'b1011110), nf, nl, ng, nx);
    check("s3_blink", nf, 8);
    wr(8'h0C, 32'h1, 2'h0);
    lamp(link_stat_t'(7'b1011100), 4'b0101, "s1_100");
    lamp(link_stat_t'(7'b1101000), 4'b1000, "s1_gig");
    lamp(link_stat_t'(7'b1101001), 4'b1000, "s1_col");
    blink16(link_stat_t'(7'b1001010), nf, nl, ng, nx);
    check("s1_10_alt", ng, 16);
    check("s1_10_duty", nf, 8);
    check("s1_half_act", nx, 8);
    wr(8'h0C, 32'h2, 2'h0);
    lamp(link_stat_t'(7'b1101000), 4'b1000, "s2_gig");
    blink16(link_stat_t'(7'b1101001), nf, nl, ng, nx);
    check("s2_col_pair", nx, 16);
    check("s2_col_duty", nl, 8);
    blink16(link_stat_t'(7'b1011110), nf, nl, ng, nx);
    check("s2_full_act", nx, 16);
    check("s2_act_blink", nl, 8);
    check("s2_100_steady", nf, 16);
    wr(8'h0C, 32'h0, 2'h0);
    lamp(link_stat_t'(7'b1001100), 4'b0011, "s0_as_s3");
    test_done();
  end
endmodule
